// File: design/timer_ab_counter_unit.v
// Purpose: Timer group of A-channel and B-channel counters behind an
//          Avalon-MM slave with a masked, sticky interrupt.
// Assumes: Pins and tick inputs are synchronous to ref_clk.
// Notes:   A channels run timer or PWM; B channels time or measure pulses.
//
// The Avalon-MM register port and the register offsets are this design's own decisions.
`timescale 1ns/10ps
`include "timer_ab_defines.vh"

module timer_ab_counter_unit #(
   parameter CW = 16,
   parameter NA = 5,
   parameter NB = 6
) (
   input  wire          ref_clk,
   input  wire          rst_n,
   input  wire [7:0]    avs_address,
   input  wire          avs_read,
   input  wire          avs_write,
   input  wire [31:0]   avs_writedata,
   input  wire [3:0]    avs_byteenable,
   output wire [31:0]   avs_readdata,
   output wire          avs_waitrequest,
   input  wire          sub_clock_tick,
   input  wire          osc_125k_tick,
   input  wire [NB-1:0] timer_b_pulse_pin,
   output wire [NA-1:0] timer_a_wave_pin,
   output wire          irq
);

   reg  [31:0]   rdata_q;
   reg           wait_q;
   reg           irq_q;
   reg  [NA-1:0] wave_q;
   reg  [NA-1:0] a_run_q;
   reg  [NB-1:0] b_run_q;
   reg  [NA-1:0] a_dir_q;
   reg  [2:0]    two_phase_q;
   reg  [NB+7:0] sts_q;
   reg  [NB+7:0] msk_q;
   reg  [CW-1:0] a_cnt_q [0:NA-1];
   reg  [CW-1:0] a_rld_q [0:NA-1];
   reg  [4:0]    a_mode_q [0:NA-1];
   reg  [NA-1:0] a_evt_q;
   reg  [CW-1:0] b_cnt_q [0:NB-1];
   reg  [CW-1:0] b_rld_q [0:NB-1];
   reg  [CW-1:0] b_cap_q [0:NB-1];
   reg  [4:0]    b_mode_q [0:NB-1];
   reg  [NB-1:0] b_ovf_q;
   reg  [NB-1:0] b_evt_q;
   reg  [NB-1:0] b_pin_q;
   reg  [31:0]   rd_mux;
   wire [5:0]    pre_tick;
   wire [6:0]    tick_vec;
   wire [5:0]    idx;
   wire [31:0]   be_mask;
   wire [31:0]   merged;
   wire          wr_fire;
   wire [NA-1:0] a_tick;
   wire [NA-1:0] a_wrap;
   wire [NB-1:0] b_tick;
   wire [NB-1:0] b_meas;
   wire [NB-1:0] b_edge;
   wire [NB+7:0] sts_set;

   // Picks the tick of the selected count source.
   function sel_tick;
      input [2:0] s;
      input [6:0] v;
      begin
         sel_tick = (s < `SRC_COUNT) ? v[s] : 1'b0;
      end
   endfunction

   // One prescaler serves every channel of both groups.
   timer_prescaler u_prescaler (
      .ref_clk        (ref_clk),
      .rst_n          (rst_n),
      .sub_clock_tick (sub_clock_tick),
      .tick           (pre_tick)
   );

   // Source vector indexed by the count source code.
   assign tick_vec = {osc_125k_tick, pre_tick};

   // Bus decode; a write lands on the edge that ends the wait.
   assign idx     = avs_address[7:2];
   assign wr_fire = avs_write & ~wait_q;
   assign be_mask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                     {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
   assign merged  = (rd_mux & ~be_mask) | (avs_writedata & be_mask);

   // Per-channel tick, wrap and edge terms.
   genvar g;
   generate
      for (g = 0; g < NA; g = g + 1) begin : gen_a
         assign a_tick[g] = a_run_q[g] &
                            sel_tick(a_mode_q[g][`MODE_SRC], tick_vec);
         assign a_wrap[g] = a_dir_q[g] ? (a_cnt_q[g] == a_rld_q[g]) :
                            (a_cnt_q[g] == {CW{1'b0}});
      end
      for (g = 0; g < NB; g = g + 1) begin : gen_b
         assign b_tick[g] = b_run_q[g] &
                            sel_tick(b_mode_q[g][`MODE_SRC], tick_vec);
         assign b_meas[g] = (b_mode_q[g][`B_MODE_FN] == `BFN_PERIOD) ||
                            (b_mode_q[g][`B_MODE_FN] == `BFN_WIDTH);
         assign b_edge[g] = b_run_q[g] & (
            (b_mode_q[g][`B_MODE_FN] == `BFN_PERIOD) ?
               (timer_b_pulse_pin[g] & ~b_pin_q[g]) :
            (b_mode_q[g][`B_MODE_FN] == `BFN_WIDTH) ?
               (timer_b_pulse_pin[g] ^ b_pin_q[g]) : 1'b0);
      end
   endgenerate

   // Read multiplexer; unmapped words read as zero.
   always @* begin : rd_mux_comb
      integer k;
      k = 0;
      rd_mux = `RST_WORD;
      case (idx)
         `IDX_RUN: begin
            rd_mux[`RUN_A_LSB +: NA] = a_run_q;
            rd_mux[`RUN_B_LSB +: NB] = b_run_q;
         end
         `IDX_UPDOWN: begin
            rd_mux[`UPDN_DIR_LSB +: NA] = a_dir_q;
            rd_mux[`UPDN_TWO_LSB +: 3]  = two_phase_q;
         end
         `IDX_STATUS: rd_mux[NB+7:0] = sts_q;
         `IDX_MASK:   rd_mux[NB+7:0] = msk_q;
         default:     rd_mux = `RST_WORD;
      endcase
      for (k = 0; k < NA; k = k + 1) begin
         if (idx == `IDX_A_MODE + k[5:0]) begin
            rd_mux[4:0] = a_mode_q[k];
         end
         if (idx == `IDX_A_COUNT + k[5:0]) begin
            rd_mux[CW-1:0] = a_cnt_q[k];
         end
      end
      for (k = 0; k < NB; k = k + 1) begin
         if (idx == `IDX_B_MODE + k[5:0]) begin
            rd_mux[5:0] = {b_ovf_q[k], b_mode_q[k]};
         end
         if (idx == `IDX_B_COUNT + k[5:0]) begin
            rd_mux[CW-1:0] = b_meas[k] ? b_cap_q[k] : b_cnt_q[k];
         end
      end
   end

   // Slave handshake: waitrequest drops one cycle after a request.
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         wait_q  <= 1'b1;
         rdata_q <= `RST_WORD;
      end else if (!wait_q) begin
         wait_q <= 1'b1;
      end else if (avs_read || avs_write) begin
         wait_q  <= 1'b0;
         rdata_q <= rd_mux;
      end
   end

   // Event sources for the sticky status.
   assign sts_set = {b_evt_q, {(8-NA){1'b0}}, a_evt_q};

   // Control, mask and sticky status; a new event beats a clear.
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         a_run_q     <= {NA{1'b0}};
         b_run_q     <= {NB{1'b0}};
         a_dir_q     <= {NA{1'b0}};
         two_phase_q <= 3'h0;
         sts_q       <= {(NB+8){1'b0}};
         msk_q       <= {(NB+8){1'b0}};
         irq_q       <= 1'b0;
      end else begin
         if (wr_fire && idx == `IDX_RUN) begin
            a_run_q <= merged[`RUN_A_LSB +: NA];
            b_run_q <= merged[`RUN_B_LSB +: NB];
         end
         if (wr_fire && idx == `IDX_UPDOWN) begin
            a_dir_q     <= merged[`UPDN_DIR_LSB +: NA];
            two_phase_q <= merged[`UPDN_TWO_LSB +: 3];
         end
         if (wr_fire && idx == `IDX_MASK) begin
            msk_q <= merged[NB+7:0];
         end
         if (wr_fire && idx == `IDX_STATUS) begin
            sts_q <= (sts_q & ~(avs_writedata[NB+7:0] & be_mask[NB+7:0]))
                     | sts_set;
         end else begin
            sts_q <= sts_q | sts_set;
         end
         irq_q <= |(sts_q & msk_q);
      end
   end

   // A channels: timer with reload, or free-running PWM.
   always @(posedge ref_clk or negedge rst_n) begin : a_chan_seq
      integer k;
      if (!rst_n) begin
         for (k = 0; k < NA; k = k + 1) begin
            a_cnt_q[k]  <= {CW{1'b0}};
            a_rld_q[k]  <= {CW{1'b0}};
            a_mode_q[k] <= `RST_MODE;
         end
         a_evt_q <= {NA{1'b0}};
         wave_q  <= {NA{1'b0}};
      end else begin
         for (k = 0; k < NA; k = k + 1) begin
            a_evt_q[k] <= a_tick[k] & a_wrap[k] &
                          ~a_mode_q[k][`A_MODE_PWM];
            if (wr_fire && idx == `IDX_A_MODE + k[5:0]) begin
               a_mode_q[k] <= merged[4:0];
            end
            if (wr_fire && idx == `IDX_A_COUNT + k[5:0]) begin
               a_rld_q[k] <= merged[CW-1:0];
               if (!a_run_q[k]) begin
                  a_cnt_q[k] <= merged[CW-1:0];
               end
            end else if (a_tick[k]) begin
               if (a_mode_q[k][`A_MODE_PWM]) begin
                  a_cnt_q[k] <= a_cnt_q[k] + 1'b1;
               end else if (a_wrap[k]) begin
                  a_cnt_q[k] <= a_dir_q[k] ? {CW{1'b0}} : a_rld_q[k];
               end else if (a_dir_q[k]) begin
                  a_cnt_q[k] <= a_cnt_q[k] + 1'b1;
               end else begin
                  a_cnt_q[k] <= a_cnt_q[k] - 1'b1;
               end
            end
            // PWM level is active below the duty value, optionally inverted.
            if (a_mode_q[k][`A_MODE_PWM]) begin
               wave_q[k] <= (a_cnt_q[k] < a_rld_q[k]) ^
                            a_mode_q[k][`A_MODE_INV];
            end else if (a_tick[k] && a_wrap[k]) begin
               wave_q[k] <= ~wave_q[k];
            end
         end
      end
   end

   // B channels: reload timer, or period and width measurement.
   always @(posedge ref_clk or negedge rst_n) begin : b_chan_seq
      integer k;
      if (!rst_n) begin
         for (k = 0; k < NB; k = k + 1) begin
            b_cnt_q[k]  <= {CW{1'b0}};
            b_rld_q[k]  <= {CW{1'b0}};
            b_cap_q[k]  <= {CW{1'b0}};
            b_mode_q[k] <= `RST_MODE;
         end
         b_ovf_q <= {NB{1'b0}};
         b_evt_q <= {NB{1'b0}};
         b_pin_q <= {NB{1'b0}};
      end else begin
         b_pin_q <= timer_b_pulse_pin;
         for (k = 0; k < NB; k = k + 1) begin
            b_evt_q[k] <= b_meas[k] ? b_edge[k] :
                          (b_tick[k] && b_cnt_q[k] == {CW{1'b0}});
            if (wr_fire && idx == `IDX_B_MODE + k[5:0]) begin
               b_mode_q[k] <= merged[4:0];
               if (!b_run_q[k] && !merged[`B_MODE_OVF]) begin
                  b_ovf_q[k] <= 1'b0;
               end
            end
            if (wr_fire && idx == `IDX_B_COUNT + k[5:0]) begin
               b_rld_q[k] <= merged[CW-1:0];
               if (b_meas[k] || !b_run_q[k]) begin
                  b_cnt_q[k] <= merged[CW-1:0];
               end
            end else if (b_meas[k]) begin
               if (b_edge[k]) begin
                  b_cap_q[k] <= b_cnt_q[k];
                  b_cnt_q[k] <= {CW{1'b0}};
               end else if (b_tick[k]) begin
                  b_cnt_q[k] <= b_cnt_q[k] + 1'b1;
                  if (b_cnt_q[k] == {CW{1'b1}}) begin
                     b_ovf_q[k] <= 1'b1;
                  end
               end
            end else if (b_tick[k]) begin
               b_cnt_q[k] <= (b_cnt_q[k] == {CW{1'b0}}) ? b_rld_q[k] :
                             b_cnt_q[k] - 1'b1;
            end
         end
      end
   end

   // Outputs straight from flip-flops.
   assign avs_readdata     = rdata_q;
   assign avs_waitrequest  = wait_q;
   assign timer_a_wave_pin = wave_q;
   assign irq              = irq_q;

endmodule // timer_ab_counter_unit

// File: design/timer_ab_defines.vh
// Purpose: Offsets, field positions, codes and reset values of the timer
//          group register map.
// Assumes: Avalon-MM byte address, one 32-bit word per register.
// Notes:   Word index is the byte address divided by four.
`ifndef TIMER_AB_DEFINES_VH
`define TIMER_AB_DEFINES_VH

// Word indices of the registers.
`define IDX_RUN         6'h00
`define IDX_UPDOWN      6'h01
`define IDX_STATUS      6'h02
`define IDX_MASK        6'h03
`define IDX_A_MODE      6'h04
`define IDX_A_COUNT     6'h0C
`define IDX_B_MODE      6'h14
`define IDX_B_COUNT     6'h1C

// Field positions.
`define RUN_A_LSB       0
`define RUN_B_LSB       8
`define UPDN_DIR_LSB    0
`define UPDN_TWO_LSB    5
`define STS_A_LSB       0
`define STS_B_LSB       8
`define MODE_SRC        2:0
`define A_MODE_PWM      3
`define A_MODE_INV      4
`define B_MODE_FN       4:3
`define B_MODE_OVF      5

// Count source codes.
`define SRC_DIV1        3'h0
`define SRC_DIV2        3'h1
`define SRC_DIV8        3'h2
`define SRC_DIV32       3'h3
`define SRC_DIV64       3'h4
`define SRC_SUB32       3'h5
`define SRC_OSC         3'h6
`define SRC_COUNT       3'h7

// B-channel functions.
`define BFN_TIMER       2'h0
`define BFN_PERIOD      2'h1
`define BFN_WIDTH       2'h2

// Prescaler terminal counts.
`define PRE_DIV8_TC     3'h7
`define PRE_DIV32_TC    5'h1F
`define PRE_DIV64_TC    6'h3F
`define SUB_DIV32_TC    5'h1F

// Reset values.
`define RST_WORD        32'h0000_0000
`define RST_MODE        5'h00

`endif

// File: design/timer_prescaler.v
// Purpose: Shared prescaler giving one-cycle count ticks for every divided
//          clock ratio used by the timer channels.
// Assumes: sub_clock_tick is a one-cycle pulse synchronous to ref_clk.
// Notes:   Tick order is divide by 1, 2, 8, 32, 64, sub-clock over 32.
`timescale 1ns/10ps
`include "timer_ab_defines.vh"

module timer_prescaler (
   input  wire       ref_clk,
   input  wire       rst_n,
   input  wire       sub_clock_tick,
   output wire [5:0] tick
);

   reg [5:0] div_q;
   reg [4:0] sub_q;
   reg [5:0] tick_q;

   // One free-running divider feeds the ref_clk ratios; sub_q divides the sub-clock.
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         div_q  <= 6'h00;
         sub_q  <= 5'h00;
         tick_q <= 6'h00;
      end else begin
         div_q     <= div_q + 6'h01;
         if (sub_clock_tick) begin
            sub_q <= sub_q + 5'h01;
         end
         tick_q[0] <= 1'b1;
         tick_q[1] <= div_q[0];
         tick_q[2] <= (div_q[2:0] == `PRE_DIV8_TC);
         tick_q[3] <= (div_q[4:0] == `PRE_DIV32_TC);
         tick_q[4] <= (div_q == `PRE_DIV64_TC);
         tick_q[5] <= sub_clock_tick && (sub_q == `SUB_DIV32_TC);
      end
   end

   assign tick = tick_q;

endmodule // timer_prescaler

// File: dv/pulse_source.sv
// Purpose: Far-side square wave on the B-channel measure pins.
// Assumes: The bench sets the half period and the enable.
// Notes:   All six pins toggle together and hold their level when idle.
`timescale 1ns/10ps
module pulse_source (
   input  wire        ref_clk,
   input  wire        rst_n,
   input  wire        en,
   input  wire [15:0] half,
   output reg  [5:0]  pin_q
);
   reg [15:0] cnt_q;
   // Toggle every half period while enabled.
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q <= 16'h0000;
         pin_q <= 6'h00;
      end else if (en) begin
         cnt_q <= (cnt_q == half - 16'h0001) ? 16'h0000 : cnt_q + 16'h0001;
         if (cnt_q == half - 16'h0001) pin_q <= ~pin_q;
      end
   end
endmodule // pulse_source

// File: dv/timer_ab_counter_unit_sva.sv
// Purpose: Bus handshake, readback and interrupt checks at the top ports.
// Assumes: One clock and an asynchronous active-low reset.
// Notes:   Helper registers shadow the run, mask and two-phase fields.
`timescale 1ns/10ps
`include "timer_ab_defines.vh"
module timer_ab_sva #(
   parameter CW = 16,
   parameter NA = 5,
   parameter NB = 6
) (
   input wire          ref_clk,
   input wire          rst_n,
   input wire [7:0]    avs_address,
   input wire          avs_read,
   input wire          avs_write,
   input wire [31:0]   avs_writedata,
   input wire [3:0]    avs_byteenable,
   input wire [31:0]   avs_readdata,
   input wire          avs_waitrequest,
   input wire          sub_clock_tick,
   input wire          osc_125k_tick,
   input wire [NB-1:0] timer_b_pulse_pin,
   input wire [NA-1:0] timer_a_wave_pin,
   input wire          irq
);
   wire          wr_done = avs_write && !avs_waitrequest;
   wire          rd_done = avs_read && !avs_waitrequest;
   wire [5:0]    idx     = avs_address[7:2];
   reg  [2:0]    two_q;
   reg  [13:0]   mask_q;
   reg  [NA-1:0] run_q;
   // Shadow what software last wrote, lane by lane.
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         two_q  <= 3'h0;
         mask_q <= 14'h0000;
         run_q  <= {NA{1'b0}};
      end else if (wr_done) begin
         if (avs_byteenable[0]) begin
            if (idx == `IDX_UPDOWN) two_q <= avs_writedata[7:5];
            if (idx == `IDX_MASK) mask_q[7:0] <= avs_writedata[7:0];
            if (idx == `IDX_RUN) run_q <= avs_writedata[NA-1:0];
         end
         // Mask bits of the second byte lane.
         if (avs_byteenable[1] && idx == `IDX_MASK)
            mask_q[13:8] <= avs_writedata[13:8];
      end
   end
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   wait_low_a: assert property ((avs_read || avs_write) && avs_waitrequest
      |=> !avs_waitrequest) else $error("request not answered");
   wait_one_a: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("waitrequest low too long");
   wait_idle_a: assert property (!avs_read && !avs_write && avs_waitrequest
      |=> avs_waitrequest) else $error("answer without request");
   rdata_hold_a: assert property ($changed(avs_readdata)
      |-> $fell(avs_waitrequest)) else $error("readdata moved");
   unmap_zero_a: assert property (rd_done && idx >= 6'h22
      |-> avs_readdata == 32'h0000_0000) else $error("unmapped read");
   updown_rb_a: assert property (rd_done && idx == `IDX_UPDOWN
      |-> avs_readdata[7:5] == two_q) else $error("two-phase readback");
   irq_mask_a: assert property (mask_q == 14'h0000 && $past(mask_q) == 14'h0000
      |-> !irq) else $error("irq while all masked");
   wave_hold_a: assert property (run_q == 0 && !$past(wr_done) &&
      !$past(wr_done, 2) && !$past(wr_done, 3) |-> $stable(timer_a_wave_pin))
      else $error("wave moved while stopped");
   cover property ($rose(irq));
   cover property (rd_done && idx >= 6'h22);
   cover property (rd_done && idx == `IDX_UPDOWN);
endmodule // timer_ab_sva
bind timer_ab_counter_unit timer_ab_sva #(.CW(CW), .NA(NA), .NB(NB)) sva_i (
   .ref_clk(ref_clk), .rst_n(rst_n), .avs_address(avs_address),
   .avs_read(avs_read), .avs_write(avs_write),
   .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
   .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
   .sub_clock_tick(sub_clock_tick), .osc_125k_tick(osc_125k_tick),
   .timer_b_pulse_pin(timer_b_pulse_pin),
   .timer_a_wave_pin(timer_a_wave_pin), .irq(irq));

// File: dv/timer_ab_counter_unit_tb.sv
// Purpose: Register-level tests of the timer group.
// Assumes: Sub-clock and oscillator ticks are scaled to short periods.
// Notes:   Measured counts allow one count of prescaler phase slack.
`timescale 1ns/10ps
`include "timer_ab_defines.vh"
module timer_ab_counter_unit_tb;
   reg         ref_clk        = 1'b0;
   reg         rst_n          = 1'b0;
   reg  [7:0]  avs_address    = 8'h00;
   reg         avs_read       = 1'b0;
   reg         avs_write      = 1'b0;
   reg  [31:0] avs_writedata  = 32'h0000_0000;
   reg  [3:0]  avs_byteenable = 4'hF;
   reg         sub_tick       = 1'b0;
   reg         osc_tick       = 1'b0;
   reg         src_en         = 1'b0;
   reg  [7:0]  tick_q         = 8'h00;
   reg  [27:0] shf            = 28'h376_5310;
   reg  [31:0] rd;
   reg  [31:0] hi;
   wire [31:0] avs_readdata;
   wire        avs_waitrequest;
   wire [5:0]  pin;
   wire [4:0]  wave;
   wire        irq;
   integer     error_cnt = 0;
   integer     n_tests   = 0;
   integer     s;
   always #5 ref_clk = ~ref_clk;
   // Sub-clock tick every 4 cycles, oscillator tick every 8.
   always @(posedge ref_clk) begin
      tick_q <= tick_q + 8'h01;
      sub_tick <= (tick_q[1:0] == 2'h3);
      osc_tick <= (tick_q[2:0] == 3'h7);
   end
   pulse_source src (.ref_clk(ref_clk), .rst_n(rst_n), .en(src_en),
      .half(16'h0100), .pin_q(pin));
   timer_ab_counter_unit uut (.ref_clk(ref_clk), .rst_n(rst_n),
      .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .sub_clock_tick(sub_tick),
      .osc_125k_tick(osc_tick), .timer_b_pulse_pin(pin),
      .timer_a_wave_pin(wave), .irq(irq));
   task chk(input string nm, input [31:0] seen, input [31:0] exp);
      n_tests = n_tests + 1;
      if (seen !== exp) begin
         error_cnt = error_cnt + 1;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task rng(input string nm, input [31:0] seen, input [31:0] lo, up);
      chk(nm, seen, ((seen >= lo) && (seen <= up)) === 1'b1 ? seen : lo);
   endtask
   // One Avalon access, held until waitrequest is sampled low.
   task bus(input w, input [5:0] idx, input [31:0] d, input [3:0] be);
      avs_address <= {idx, 2'b00};
      avs_writedata <= d;
      avs_byteenable <= be;
      avs_read <= !w;
      avs_write <= w;
      @(posedge ref_clk);
      while (avs_waitrequest !== 1'b0) @(posedge ref_clk);
      rd = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(posedge ref_clk);
   endtask
   task wr(input [5:0] idx, input [31:0] d);
      bus(1'b1, idx, d, 4'hF);
   endtask
   task rdc(input string nm, input [5:0] idx, input [31:0] exp);
      bus(1'b0, idx, 32'h0000_0000, 4'hF);
      chk(nm, rd, exp);
   endtask
   task end_sim;
      $display("tests %0d errors %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // Watchdog well beyond the expected run length.
   initial begin
      #(60000 * 10);
      error_cnt = error_cnt + 1;
      end_sim;
   end
   // Main test sequence.
   initial begin
      repeat (4) @(posedge ref_clk);
      rst_n <= 1'b1;
      @(posedge ref_clk);
      rdc("run rst", `IDX_RUN, 32'h0000_0000);
      wr(6'h3F, 32'hFFFF_FFFF);
      rdc("unmapped", 6'h3F, 32'h0000_0000);
      wr(`IDX_UPDOWN, 32'h0000_00A0);
      bus(1'b1, `IDX_UPDOWN, 32'h0000_00FF, 4'hE);
      rdc("updown", `IDX_UPDOWN, 32'h0000_00A0);
      wr(`IDX_A_COUNT, 32'h0000_0100);
      wr(`IDX_RUN, 32'h0000_0001);
      repeat (8) @(posedge ref_clk);
      bus(1'b0, `IDX_A_COUNT, 32'h0000_0000, 4'hF);
      rng("a down", rd, 32'h0000_00E0, 32'h0000_00FF);
      wr(`IDX_RUN, 32'h0000_0000);
      wr(`IDX_UPDOWN, 32'h0000_0041);
      rdc("updown up", `IDX_UPDOWN, 32'h0000_0041);
      wr(`IDX_A_COUNT, 32'h0000_0100);
      wr(`IDX_RUN, 32'h0000_0001);
      repeat (8) @(posedge ref_clk);
      bus(1'b0, `IDX_A_COUNT, 32'h0000_0000, 4'hF);
      rng("a up", rd, 32'h0000_0000, 32'h0000_0020);
      wr(`IDX_A_COUNT, 32'h0000_0000);
      wr(`IDX_A_MODE, 32'h0000_0008);
      repeat (3) @(posedge ref_clk);
      chk("pwm", wave[0], 1'b0);
      wr(`IDX_A_MODE, 32'h0000_0018);
      repeat (3) @(posedge ref_clk);
      chk("pwm inv", wave[0], 1'b1);
      src_en <= 1'b1;
      for (s = 0; s < 7; s = s + 1) begin
         wr(`IDX_RUN, 32'h0000_0000);
         wr(`IDX_B_MODE, s | 32'h0000_0008);
         wr(`IDX_B_COUNT, 32'h0000_0000);
         wr(`IDX_RUN, 32'h0000_0100);
         repeat (1600) @(posedge ref_clk);
         bus(1'b0, `IDX_B_COUNT, 32'h0000_0000, 4'hF);
         hi = 32'h0000_0200 >> shf[4*s +: 4];
         rng("b period", rd, hi - 32'h0000_0001, hi);
      end
      chk("irq masked", irq, 1'b0);
      wr(`IDX_MASK, 32'h0000_0100);
      @(posedge ref_clk);
      chk("irq", irq, 1'b1);
      wr(`IDX_RUN, 32'h0000_0000);
      wr(`IDX_MASK, 32'h0000_0000);
      @(posedge ref_clk);
      chk("irq off", irq, 1'b0);
      bus(1'b0, `IDX_STATUS, 32'h0000_0000, 4'hF);
      chk("sticky", rd[8], 1'b1);
      chk("a wrap", rd[0], 1'b1);
      wr(`IDX_STATUS, 32'h0000_3FFF);
      rdc("sts clr", `IDX_STATUS, 32'h0000_0000);
      src_en <= 1'b0;
      wr(`IDX_B_MODE, 32'h0000_0010);
      wr(`IDX_B_COUNT, 32'h0000_FFF0);
      wr(`IDX_RUN, 32'h0000_0100);
      repeat (20) @(posedge ref_clk);
      wr(`IDX_RUN, 32'h0000_0000);
      bus(1'b0, `IDX_B_MODE, 32'h0000_0000, 4'hF);
      chk("ovf set", rd[5], 1'b1);
      wr(`IDX_B_MODE, 32'h0000_0010);
      repeat (20) @(posedge ref_clk);
      bus(1'b0, `IDX_B_MODE, 32'h0000_0000, 4'hF);
      chk("ovf clr", rd[5], 1'b0);
      // B timer mode: count down from three, underflow reloads and flags.
      wr(`IDX_B_MODE, 32'h0000_0000);
      wr(`IDX_B_COUNT, 32'h0000_0003);
      wr(`IDX_STATUS, 32'h0000_3FFF);
      wr(`IDX_RUN, 32'h0000_0100);
      repeat (8) @(posedge ref_clk);
      wr(`IDX_RUN, 32'h0000_0000);
      bus(1'b0, `IDX_STATUS, 32'h0000_0000, 4'hF);
      chk("b underflow", rd[8], 1'b1);
      bus(1'b0, `IDX_B_COUNT, 32'h0000_0000, 4'hF);
      rng("b reload", rd, 32'h0000_0000, 32'h0000_0003);
      end_sim;
   end
endmodule // timer_ab_counter_unit_tb
